/* lgs_sequencer.sv */
// LED gradation sequencer with AHB-Lite register slave
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module lgs_sequencer
  import lgs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pins
  input wire logic outputEnableN,
  input wire logic ext_timebase_in,
  // LED drive
  output logic [NUM_CH-1:0] ledOn,
  output logic [NUM_CH-1:0][5:0] ledLevel,
  output logic [NUM_CH-1:0] ledDriveEn
);

  // Configuration storage
  lgs_ctrl_t ctrl_r;
  logic [DUR_W-1:0] slotDuration_r;
  logic [7:0] gridSlot_r [NUM_BANK][NUM_SLOT];
  lgs_chan_t chanCfg_r [NUM_BANK][NUM_CH];

  // Bus state
  logic wrPend_r;
  logic [11:0] wrAddr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic [31:0] rdMux;
  logic addrOk;
  logic accept;

  // Pin synchronisers
  logic oeS1_r;
  logic oeS2_r;
  logic tbS1_r;
  logic tbS2_r;
  logic tbS3_r;
  logic tbEdge;

  // Sequencer state
  lgs_state_t state_r;
  logic [5:0] slot_r;
  logic execBank_r;
  logic [DUR_W-1:0] durCnt_r;
  logic startCond;
  logic startEv;
  logic stopEv;
  logic slotEnd;
  logic seqEvent;

  // Stagger state
  logic stagBusy_r;
  logic [4:0] stagIdx_r;
  logic [3:0] stagCnt_r;

  // Per-channel targets
  logic [NUM_CH-1:0] tgtOn;
  logic [NUM_CH-1:0][5:0] tgtLevel;

  // Output flops
  logic [NUM_CH-1:0] ledOn_r;
  logic [NUM_CH-1:0][5:0] ledLevel_r;
  logic [NUM_CH-1:0] ledDriveEn_r;

  // Address phase decode
  assign accept = hsel & hready & htrans[1];
  assign addrOk = (haddr[31:12] == 20'h00000) & (haddr[1:0] == 2'h0);

  // Read multiplexer, access bank view
  always_comb begin
    logic [11:0] a;
    logic [11:0] off;
    lgs_chan_t c;
    a = haddr[11:0];
    off = 12'h000;
    c = CHAN_RST;
    rdMux = 32'h00000000;
    if (addrOk) begin
      if (a == ADDR_CTRL) begin
        rdMux = {27'h0000000, ctrl_r};
      end else if (a == ADDR_DUR) begin
        rdMux = {16'h0000, slotDuration_r};
      end else if (a == ADDR_STAT) begin
        rdMux[STAT_SLOT_LSB +: 6] = slot_r;
        rdMux[STAT_BANK] = execBank_r;
        rdMux[STAT_RUN] = (state_r == SEQ_RUN);
        rdMux[STAT_HOLD] = (state_r == SEQ_HOLD);
      end else if (a >= ADDR_GRID_BASE && a < ADDR_GRID_END) begin
        rdMux = {24'h000000, gridSlot_r[ctrl_r.accessBank][a[7:2]]};
      end else if (a >= ADDR_CHAN_BASE && a < ADDR_CHAN_END) begin
        off = a - ADDR_CHAN_BASE;
        c = chanCfg_r[ctrl_r.accessBank][off[8:4]];
        case (off[3:2])
          CW_CFG: rdMux = {29'h00000000, c.channelGroupSelect, c.channelOutputEnable};
          CW_LVL1: rdMux = {26'h0000000, c.presetLevel1};
          CW_LVL2: rdMux = {26'h0000000, c.presetLevel2};
          CW_LVL3: rdMux = {26'h0000000, c.presetLevel3};
          default: rdMux = 32'h00000000;
        endcase
      end
    end
  end

  // Bus pipeline: read data latched in address phase, write held to data phase
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 12'h000;
      hrdata_r <= 32'h00000000;
    end else begin
      wrPend_r <= accept & hwrite & addrOk;
      if (accept) begin
        wrAddr_r <= haddr[11:0];
        hrdata_r <= hwrite ? 32'h00000000 : rdMux;
      end
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  // Control and duration registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RST;
      slotDuration_r <= DUR_RST;
    end else if (wrPend_r) begin
      if (wrAddr_r == ADDR_CTRL) begin
        ctrl_r <= hwdata[4:0];
      end
      if (wrAddr_r == ADDR_DUR) begin
        slotDuration_r <= hwdata[DUR_W-1:0];
      end
    end
  end

  // Bank storage, written into the access bank
  always_ff @(posedge sys_clk or negedge rstn) begin
    logic [11:0] off;
    if (!rstn) begin
      for (int b = 0; b < NUM_BANK; b++) begin
        for (int s = 0; s < NUM_SLOT; s++) begin
          gridSlot_r[b][s] <= 8'h00;
        end
        for (int ch = 0; ch < NUM_CH; ch++) begin
          chanCfg_r[b][ch] <= CHAN_RST;
        end
      end
    end else if (wrPend_r) begin
      off = wrAddr_r - ADDR_CHAN_BASE;
      if (wrAddr_r >= ADDR_GRID_BASE && wrAddr_r < ADDR_GRID_END) begin
        gridSlot_r[ctrl_r.accessBank][wrAddr_r[7:2]] <= hwdata[7:0];
      end
      if (wrAddr_r >= ADDR_CHAN_BASE && wrAddr_r < ADDR_CHAN_END) begin
        case (off[3:2])
          CW_CFG: begin
            chanCfg_r[ctrl_r.accessBank][off[8:4]].channelOutputEnable <= hwdata[0];
            chanCfg_r[ctrl_r.accessBank][off[8:4]].channelGroupSelect <= hwdata[2:1];
          end
          CW_LVL1: chanCfg_r[ctrl_r.accessBank][off[8:4]].presetLevel1 <= hwdata[5:0];
          CW_LVL2: chanCfg_r[ctrl_r.accessBank][off[8:4]].presetLevel2 <= hwdata[5:0];
          CW_LVL3: chanCfg_r[ctrl_r.accessBank][off[8:4]].presetLevel3 <= hwdata[5:0];
          default: ;
        endcase
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      oeS1_r <= 1'b1;
      oeS2_r <= 1'b1;
      tbS1_r <= 1'b0;
      tbS2_r <= 1'b0;
      tbS3_r <= 1'b0;
    end else begin
      oeS1_r <= outputEnableN;
      oeS2_r <= oeS1_r;
      tbS1_r <= ext_timebase_in;
      tbS2_r <= tbS1_r;
      tbS3_r <= tbS2_r;
    end
  end

  assign tbEdge = tbS2_r & ~tbS3_r;

  // Sequence events
  always_comb begin
    startCond = ~oeS2_r & ctrl_r.sequenceEnable;
    startEv = (state_r == SEQ_IDLE) & startCond;
    stopEv = (state_r != SEQ_IDLE) & ~startCond;
    slotEnd = (state_r == SEQ_RUN) & startCond & tbEdge & (durCnt_r <= DUR_ONE);
    seqEvent = startEv | stopEv | (slotEnd & ((slot_r != LAST_SLOT) |
               ctrl_r.sequenceRepeatSelect));
  end

  // Slot stepping
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= SEQ_IDLE;
      slot_r <= FIRST_SLOT;
      execBank_r <= 1'b0;
      durCnt_r <= DUR_RST;
    end else begin
      case (state_r)
        SEQ_IDLE: begin
          if (startEv) begin
            state_r <= SEQ_RUN;
            slot_r <= FIRST_SLOT;
            execBank_r <= ctrl_r.executingBankSelect;
            durCnt_r <= slotDuration_r;
          end
        end
        SEQ_RUN: begin
          if (stopEv) begin
            state_r <= SEQ_IDLE;
          end else if (slotEnd) begin
            if (slot_r == LAST_SLOT) begin
              if (ctrl_r.sequenceRepeatSelect) begin
                slot_r <= FIRST_SLOT;
                execBank_r <= ctrl_r.executingBankSelect;
                durCnt_r <= slotDuration_r;
              end else begin
                state_r <= SEQ_HOLD;
              end
            end else begin
              slot_r <= slot_r + 6'h01;
              durCnt_r <= slotDuration_r;
            end
          end else if (tbEdge) begin
            durCnt_r <= durCnt_r - DUR_ONE;
          end
        end
        SEQ_HOLD: begin
          if (stopEv) begin
            state_r <= SEQ_IDLE;
          end
        end
        default: state_r <= SEQ_IDLE;
      endcase
    end
  end

  // Target current per channel from executing bank
  always_comb begin
    lgs_chan_t c;
    logic [7:0] g;
    logic [1:0] sel;
    c = CHAN_RST;
    g = 8'h00;
    sel = SEL_OFF;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      c = chanCfg_r[execBank_r][ch];
      g = gridSlot_r[execBank_r][slot_r];
      sel = g[2*c.channelGroupSelect +: 2];
      tgtOn[ch] = (state_r != SEQ_IDLE) & c.channelOutputEnable & (sel != SEL_OFF);
      case (sel)
        SEL_L1: tgtLevel[ch] = c.presetLevel1;
        SEL_L2: tgtLevel[ch] = c.presetLevel2;
        SEL_L3: tgtLevel[ch] = c.presetLevel3;
        default: tgtLevel[ch] = 6'h00;
      endcase
    end
  end

  // Stagger walker, channel 0 first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stagBusy_r <= 1'b0;
      stagIdx_r <= FIRST_CH;
      stagCnt_r <= 4'h0;
    end else if (oeS2_r || seqEvent) begin
      stagBusy_r <= seqEvent & ~oeS2_r;
      stagIdx_r <= FIRST_CH;
      stagCnt_r <= 4'h0;
    end else if (stagBusy_r) begin
      if (ctrl_r.staggerDisable || (stagIdx_r == LAST_CH && stagCnt_r == STAG_CYC - 4'h1)) begin
        stagBusy_r <= 1'b0;
      end else if (stagCnt_r == STAG_CYC - 4'h1) begin
        stagCnt_r <= 4'h0;
        stagIdx_r <= stagIdx_r + 5'h01;
      end else begin
        stagCnt_r <= stagCnt_r + 4'h1;
      end
    end
  end

  // Output drive
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ledOn_r <= '0;
      ledLevel_r <= '0;
      ledDriveEn_r <= '0;
    end else begin
      ledDriveEn_r <= {NUM_CH{~oeS2_r}};
      if (oeS2_r) begin
        ledOn_r <= '0;
      end else if (stagBusy_r) begin
        for (int ch = 0; ch < NUM_CH; ch++) begin
          if (ctrl_r.staggerDisable || stagIdx_r == 5'(ch)) begin
            ledOn_r[ch] <= tgtOn[ch];
            ledLevel_r[ch] <= tgtLevel[ch];
          end
        end
      end
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign ledOn = ledOn_r;
  assign ledLevel = ledLevel_r;
  assign ledDriveEn = ledDriveEn_r;

endmodule

/* lgs_pkg.sv */
// Constants, field layouts and types of the LED gradation sequencer
package lgs_pkg;

  // Channel, group and slot counts
  localparam int NUM_CH = 24;
  localparam int NUM_GRP = 4;
  localparam int NUM_SLOT = 64;
  localparam int NUM_BANK = 2;
  localparam logic [5:0] FIRST_SLOT = 6'h00;
  localparam logic [5:0] LAST_SLOT = 6'h3F;
  localparam logic [4:0] FIRST_CH = 5'h00;
  localparam logic [4:0] LAST_CH = 5'h17;

  // Group selector codes
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_L1 = 2'h1;
  localparam logic [1:0] SEL_L2 = 2'h2;
  localparam logic [1:0] SEL_L3 = 2'h3;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_DUR = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [11:0] ADDR_GRID_BASE = 12'h100;
  localparam logic [11:0] ADDR_GRID_END = 12'h200;
  localparam logic [11:0] ADDR_CHAN_BASE = 12'h200;
  localparam logic [11:0] ADDR_CHAN_END = 12'h380;

  // Channel word kinds
  localparam logic [1:0] CW_CFG = 2'h0;
  localparam logic [1:0] CW_LVL1 = 2'h1;
  localparam logic [1:0] CW_LVL2 = 2'h2;
  localparam logic [1:0] CW_LVL3 = 2'h3;

  // Slot duration
  localparam int DUR_W = 16;
  localparam logic [DUR_W-1:0] DUR_RST = 16'h0000;
  localparam logic [DUR_W-1:0] DUR_ONE = 16'h0001;

  // Stagger timing
  localparam int STAGGER_NS = 50;
  localparam int SYS_CLK_MHZ = 40;
  localparam int STAG_CYC_INT = (STAGGER_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] STAG_CYC = 4'(STAG_CYC_INT < 1 ? 1 : STAG_CYC_INT);

  // Control register, bit 0 is sequenceEnable
  typedef struct packed {
    logic accessBank;
    logic executingBankSelect;
    logic staggerDisable;
    logic sequenceRepeatSelect;
    logic sequenceEnable;
  } lgs_ctrl_t;
  localparam lgs_ctrl_t CTRL_RST = 5'h00;

  // Per-channel configuration of one bank
  typedef struct packed {
    logic channelOutputEnable;
    logic [1:0] channelGroupSelect;
    logic [5:0] presetLevel1;
    logic [5:0] presetLevel2;
    logic [5:0] presetLevel3;
  } lgs_chan_t;
  localparam lgs_chan_t CHAN_RST = 21'h000000;

  // Status register bit positions
  localparam int STAT_SLOT_LSB = 0;
  localparam int STAT_BANK = 6;
  localparam int STAT_RUN = 7;
  localparam int STAT_HOLD = 8;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_HOLD} lgs_state_t;

endpackage

/* lgs_sequencer_asserts.sv */
// Port checker of the LED gradation sequencer
`timescale 1ns/1ps
module lgs_sequencer_asserts
  import lgs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pin and drive
  input wire logic outputEnableN,
  input wire logic [NUM_CH-1:0] ledOn,
  input wire logic [NUM_CH-1:0] ledDriveEn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic take;
  assign take = hsel && hready && htrans[1];
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("slave inserted a wait");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("slave gave an error");
  property p_rdHold; !take |=> $stable(hrdata); endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data moved");
  property p_unmapped; take && !hwrite && haddr[31:12] != 20'h00000 |=> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_offAtOnce; $rose(outputEnableN) |-> ##[1:4] (ledOn == '0); endproperty
  a_offAtOnce: assert property (p_offAtOnce) else $error("outputs not off together");
  property p_hiZ; outputEnableN [*5] |-> ledDriveEn == '0 && ledOn == '0; endproperty
  a_hiZ: assert property (p_hiZ) else $error("outputs driven while pin high");
  property p_drive; !outputEnableN [*5] |-> ledDriveEn == '1; endproperty
  a_drive: assert property (p_drive) else $error("outputs not enabled while pin low");
  property p_litDriven; (ledOn & ~ledDriveEn) == '0; endproperty
  a_litDriven: assert property (p_litDriven) else $error("channel on while undriven");
  c_rise: cover property ($rose(outputEnableN));
  c_lit: cover property (ledDriveEn == '1 && ledOn != '0);
  c_unmapped: cover property (take && haddr[31:12] != 20'h00000);
endmodule

bind lgs_sequencer lgs_sequencer_asserts u_chk (.sys_clk, .rstn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .outputEnableN, .ledOn, .ledDriveEn);

/* lgs_led_load.sv */
// LED load and timebase oscillator facing the sequencer
`timescale 1ns/1ps
module lgs_led_load
  import lgs_pkg::*;
#(
  parameter realtime HALF_NS = 100.0
)
(
  // Clock and drive
  input wire logic sys_clk,
  input wire logic [NUM_CH-1:0] ledOn,
  input wire logic [NUM_CH-1:0] ledDriveEn,
  // Timebase and switch-on times
  output logic ext_timebase_in,
  output int stamp [NUM_CH]
);
  int cyc = 0;
  logic [NUM_CH-1:0] lit;
  logic [NUM_CH-1:0] litPrev = '0;
  assign lit = ledOn & ledDriveEn;
  // Free running oscillator
  initial begin
    ext_timebase_in = 1'b0;
    #7;
    forever #(HALF_NS) ext_timebase_in = ~ext_timebase_in;
  end
  // Cycle at which each load lights
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    litPrev <= lit;
    for (int k = 0; k < NUM_CH; k++) begin
      if (lit[k] && !litPrev[k]) stamp[k] <= cyc;
    end
  end
endmodule

/* tb_top.sv */
// Self-checking testbench of the LED gradation sequencer
`timescale 1ns/1ps
module tb_top;
  import lgs_pkg::*;
  logic sys_clk = 0, rstn = 0, hsel = 0, hwrite = 0, outputEnableN = 1, rdPh = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hready, hresp, ext_timebase_in;
  logic [NUM_CH-1:0] ledOn, ledDriveEn, en;
  logic [NUM_CH-1:0][5:0] ledLevel;
  logic [1:0] grp [NUM_CH];
  logic [5:0] lvl [NUM_CH][4];
  logic [7:0] slotW [NUM_SLOT];
  logic [16:0] seed = 17'h11999;
  int stamp [NUM_CH];
  int bad_count = 0, n_tests = 0, cyc = 0, probe = 0;
  string nameQ [$];
  logic [31:0] expQ [$], maskQ [$];

  lgs_sequencer dut (.sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .outputEnableN, .ext_timebase_in,
    .ledOn, .ledLevel, .ledDriveEn);
  lgs_led_load load (.sys_clk, .ledOn, .ledDriveEn, .ext_timebase_in, .stamp);

  initial forever #12.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed = {seed[15:0], seed[16] ^ seed[13]};
    return {15'h0000, seed};
  endfunction
  function automatic logic [31:0] got(int p);
    if (p == 1) return {8'h00, ledOn};
    if (p == 2) return {8'h00, ledDriveEn};
    if (p < 40) return {26'h0000000, ledLevel[p-8]};
    return 32'(stamp[p-40] - stamp[0]);
  endfunction
  task automatic note(string n, logic [31:0] e, logic [31:0] m);
    nameQ.push_back(n);
    expQ.push_back(e);
    maskQ.push_back(m);
  endtask
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] d, logic [31:0] m);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) note("hrdata", d, m);
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    xfer(1'b1, {20'h00000, a}, d, 32'h0);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m);
    xfer(1'b0, {20'h00000, a}, e, m);
  endtask
  task automatic look(string n, int p, logic [31:0] e);
    note(n, e, 32'hFFFFFFFF);
    probe <= p;
    @(posedge sys_clk);
    probe <= 0;
    @(posedge sys_clk);
  endtask
  task automatic checkSlot(int s);
    logic [1:0] sel;
    logic [23:0] on;
    for (int k = 0; k < NUM_CH; k++) begin
      sel = 2'(slotW[s] >> (2 * grp[k]));
      on[k] = en[k] && sel != SEL_OFF;
      if (on[k]) look("ledLevel", 8 + k, {26'h0000000, lvl[k][sel]});
    end
    look("ledOn", 1, {8'h00, on});
  endtask
  task automatic cmp(logic [31:0] g);
    string n;
    logic [31:0] e, m;
    n = nameQ.pop_front();
    e = expQ.pop_front();
    m = maskQ.pop_front();
    n_tests++;
    if ((g & m) !== (e & m)) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e & m, g & m);
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watches results and takes the oldest note
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rdPh && hready === 1'b1) cmp(hrdata);
    if (probe != 0) cmp(got(probe));
    if (hready === 1'b1) rdPh <= hsel && htrans[1] && !hwrite;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    logic [31:0] g0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(ADDR_DUR, 32'h0, 32'hFFFFFFFF);
    rd(ADDR_CHAN_BASE, 32'h0, 32'hFFFFFFFF);
    xfer(1'b0, 32'h00001000, 32'h0, 32'hFFFFFFFF);
    g0 = rnd() & 32'hFF;
    wr(ADDR_GRID_BASE + 12'h004, g0);
    wr(ADDR_CTRL, 32'h10);
    wr(ADDR_GRID_BASE + 12'h004, ~g0 & 32'hFF);
    rd(ADDR_GRID_BASE + 12'h004, ~g0, 32'hFF);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_GRID_BASE + 12'h004, g0, 32'hFF);
    for (int k = 0; k < NUM_CH; k++) begin
      en[k] = (k != 4);
      grp[k] = 2'(rnd());
      wr(ADDR_CHAN_BASE + 12'(16 * k), {29'h0, grp[k], en[k]});
      for (int j = 1; j < 4; j++) begin
        lvl[k][j] = 6'(rnd());
        wr(ADDR_CHAN_BASE + 12'(16 * k + 4 * j), {26'h0, lvl[k][j]});
      end
    end
    for (int s = 0; s < NUM_SLOT; s++) begin
      slotW[s] = (s == 0) ? 8'hFF : 8'(rnd());
      wr(ADDR_GRID_BASE + 12'(4 * s), {24'h000000, slotW[s]});
    end
    wr(ADDR_DUR, 32'h100);
    outputEnableN <= 1'b0;
    wr(ADDR_CTRL, 32'h1);
    repeat (60) @(posedge sys_clk);
    for (int k = 0; k < NUM_CH; k++) begin
      if (en[k]) look("stagger", 40 + k, 32'(k * STAG_CYC));
    end
    look("ledDriveEn", 2, 32'hFFFFFF);
    checkSlot(0);
    rd(ADDR_STAT, 32'h80, 32'hFF);
    wr(ADDR_DUR, 32'h1);
    repeat (3000) @(posedge sys_clk);
    rd(ADDR_STAT, 32'h13F, 32'h13F);
    checkSlot(63);
    outputEnableN <= 1'b1;
    repeat (5) @(posedge sys_clk);
    look("ledOn", 1, 32'h0);
    look("ledDriveEn", 2, 32'h0);
    rd(ADDR_STAT, 32'h0, 32'h180);
    wr(ADDR_DUR, 32'h100);
    wr(ADDR_CTRL, 32'h7);
    outputEnableN <= 1'b0;
    repeat (10) @(posedge sys_clk);
    for (int k = 0; k < NUM_CH; k++) begin
      if (en[k]) look("stagger", 40 + k, 32'h0);
    end
    rd(ADDR_STAT, 32'h80, 32'hFF);
    wr(ADDR_CTRL, 32'hF);
    rd(ADDR_STAT, 32'h80, 32'hC0);
    wr(ADDR_DUR, 32'h1);
    repeat (3000) @(posedge sys_clk);
    rd(ADDR_STAT, 32'hC0, 32'h1C0);
    look("ledOn", 1, 32'h0);
    end_sim();
  end
endmodule
